// ===== core/lcr_defs.vh
`ifndef LCR_DEFS_VH
`define LCR_DEFS_VH

// ==========================================================
// Register byte addresses
`define LCR_ADDR_ALIAS_LO     16'h0012
`define LCR_ADDR_ALIAS_HI     16'h0013
`define LCR_ADDR_RST_KEY      16'h0041
`define LCR_ADDR_CTRL_B0      16'h0100
`define LCR_ADDR_CTRL_B1      16'h0101
`define LCR_ADDR_CTRL_B2      16'h0102
`define LCR_ADDR_CTRL_B3      16'h0103
`define LCR_ADDR_RWOFS_LO     16'h0108
`define LCR_ADDR_RWOFS_HI     16'h0109

// ==========================================================
// Reset key bytes and progress codes
`define LCR_KEY_1             8'h52
`define LCR_KEY_2             8'h45
`define LCR_KEY_3             8'h53
`define LCR_PROG_NONE         2'h0
`define LCR_PROG_ONE          2'h1
`define LCR_PROG_TWO          2'h2

// ==========================================================
// Link control field positions and reset values
`define LCR_BIT_FWD_RULE      0
`define LCR_BIT_TEMP          1
`define LCR_BIT_FIFO_LO       16
`define LCR_BIT_JITTER        19
`define LCR_BIT_ALIAS_EN      24
`define LCR_CTRL_RESET        32'h0007_0001
`define LCR_CTRL_WMASK        32'h010F_3F03
`define LCR_FIFO_DEFAULT      3'h7

// ==========================================================
// Timing: temporary loop interval of about one second
`define LCR_TEMP_NS           1000000000
`define LCR_CLK_NS            40
`define LCR_TEMP_CYCLES       (`LCR_TEMP_NS / `LCR_CLK_NS)

`endif

// ===== core/lcr_regs.v
`timescale 1ns/10ps
`include "lcr_defs.vh"

module lcr_regs #(
    parameter TEMP_CYCLES = `LCR_TEMP_CYCLES,
    parameter NPORTS      = 3
) (
    input  wire        clk,
    input  wire        rst,
    // Network-side byte access
    input  wire        net_wr,
    input  wire        net_rd,
    input  wire [15:0] net_addr,
    input  wire [7:0]  net_wdata,
    output reg  [7:0]  net_rdata,
    // Host-side byte access
    input  wire        host_wr,
    input  wire        host_rd,
    input  wire [15:0] host_addr,
    input  wire [7:0]  host_wdata,
    output reg  [7:0]  host_rdata,
    // Frame activity per port, high while a frame is in flight
    input  wire [2:0]  port_busy,
    // Command address path for combined read-write commands
    input  wire [15:0] cmd_addr,
    output reg  [15:0] cmd_wr_addr,
    // Sender address bit 1 of a forwarded frame
    input  wire        fwd_sender_bit1_in,
    output reg         fwd_sender_bit1_out,
    // Applied settings
    output reg         host_if_reset,
    output reg         alias_match_en,
    output reg  [15:0] station_alias,
    output reg         low_jitter,
    output reg  [2:0]  rx_fifo_size,
    output reg  [3:0]  diff_delay_red,
    output reg         mii_delay_red,
    output reg  [5:0]  loop_applied,
    output reg         drop_non_fieldbus
);

    // ==========================================================
    // Storage
    reg [31:0] ctrl_r;
    reg [31:0] ctrl_nxt;
    reg [15:0] rwofs_r;
    reg [15:0] alias_r;
    reg [1:0]  prog_r;
    reg [5:0]  loop_saved_r;
    reg        temp_act_r;
    reg [31:0] temp_cnt_r;
    reg        loop_written;
    reg [7:0]  net_rdata_nxt;
    reg [7:0]  host_rdata_nxt;
    reg [3:0]  diff_red_nxt;
    reg        mii_red_nxt;

    // Writable bits per byte; reserved bits stay zero and read back zero
    localparam [31:0] CTRL_WMASK = `LCR_CTRL_WMASK;

    wire [5:0]  loop_ctrl = ctrl_r[13:8];
    // Carry out of the offset addition is dropped: the write address wraps
    wire [16:0] cmd_sum   = {1'b0, cmd_addr} + {1'b0, rwofs_r};

    // ==========================================================
    // Network writes to link control, byte by byte, little-endian
    always @* begin
        ctrl_nxt = ctrl_r;
        loop_written = 1'b0;
        if (net_wr) begin
            if (net_addr == `LCR_ADDR_CTRL_B0) begin
                ctrl_nxt[7:0] = net_wdata & CTRL_WMASK[7:0];
            end else if (net_addr == `LCR_ADDR_CTRL_B1) begin
                ctrl_nxt[15:8] = net_wdata & CTRL_WMASK[15:8];
                loop_written = 1'b1;
            end else if (net_addr == `LCR_ADDR_CTRL_B2) begin
                ctrl_nxt[23:16] = net_wdata & CTRL_WMASK[23:16];
            end else if (net_addr == `LCR_ADDR_CTRL_B3) begin
                ctrl_nxt[31:24] = net_wdata & CTRL_WMASK[31:24];
            end
        end
    end

    // Control, saved loop settings and temporary-revert timer
    always @(posedge clk) begin
        if (rst) begin
            ctrl_r       <= `LCR_CTRL_RESET;
            loop_saved_r <= 6'h00;
            temp_act_r   <= 1'b0;
            temp_cnt_r   <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            // Save the old settings at the first temporary write, and restart the interval at each one
            if (loop_written && ctrl_nxt[`LCR_BIT_TEMP]) begin
                if (!temp_act_r) begin
                    loop_saved_r <= loop_ctrl;
                end
                temp_act_r <= 1'b1;
                temp_cnt_r <= TEMP_CYCLES;
            end else if (temp_act_r) begin
                if (temp_cnt_r <= 32'h0000_0001) begin
                    temp_act_r   <= 1'b0;
                    ctrl_r[13:8] <= loop_saved_r;
                end else begin
                    temp_cnt_r <= temp_cnt_r - 32'h0000_0001;
                end
            end
        end
    end

    // ==========================================================
    // Read/write offset for combined commands, written from the network side
    always @(posedge clk) begin
        if (rst) begin
            rwofs_r <= 16'h0000;
        end else if (net_wr && net_addr == `LCR_ADDR_RWOFS_LO) begin
            rwofs_r[7:0] <= net_wdata;
        end else if (net_wr && net_addr == `LCR_ADDR_RWOFS_HI) begin
            rwofs_r[15:8] <= net_wdata;
        end
    end

    // ==========================================================
    // Host-side alias register and reset key sequence
    // A write anywhere else from the host breaks the key sequence,
    // so a stray access cannot complete a half-entered key.
    always @(posedge clk) begin
        if (rst) begin
            alias_r       <= 16'h0000;
            prog_r        <= `LCR_PROG_NONE;
            host_if_reset <= 1'b0;
        end else begin
            host_if_reset <= 1'b0;
            if (host_wr && host_addr == `LCR_ADDR_ALIAS_LO) begin
                alias_r[7:0] <= host_wdata;
            end else if (host_wr && host_addr == `LCR_ADDR_ALIAS_HI) begin
                alias_r[15:8] <= host_wdata;
            end
            if (host_wr) begin
                if (host_addr != `LCR_ADDR_RST_KEY) begin
                    prog_r <= `LCR_PROG_NONE;
                end else if (host_wdata == `LCR_KEY_1) begin
                    prog_r <= `LCR_PROG_ONE;
                end else if (host_wdata == `LCR_KEY_2 && prog_r == `LCR_PROG_ONE) begin
                    prog_r <= `LCR_PROG_TWO;
                end else if (host_wdata == `LCR_KEY_3 && prog_r == `LCR_PROG_TWO) begin
                    prog_r        <= `LCR_PROG_NONE;
                    host_if_reset <= 1'b1;
                end else begin
                    prog_r <= `LCR_PROG_NONE;
                end
            end
        end
    end

    // ==========================================================
    // Read selection per side; unmapped bytes and reserved bits read zero.
    // Both sides see the same map; only the writes differ between them.
    always @* begin
        net_rdata_nxt = 8'h00;
        if (net_addr == `LCR_ADDR_RST_KEY) begin
            net_rdata_nxt = {6'h00, prog_r};
        end else if (net_addr == `LCR_ADDR_CTRL_B0) begin
            net_rdata_nxt = ctrl_r[7:0];
        end else if (net_addr == `LCR_ADDR_CTRL_B1) begin
            net_rdata_nxt = ctrl_r[15:8];
        end else if (net_addr == `LCR_ADDR_CTRL_B2) begin
            net_rdata_nxt = ctrl_r[23:16];
        end else if (net_addr == `LCR_ADDR_CTRL_B3) begin
            net_rdata_nxt = ctrl_r[31:24];
        end else if (net_addr == `LCR_ADDR_RWOFS_LO) begin
            net_rdata_nxt = rwofs_r[7:0];
        end else if (net_addr == `LCR_ADDR_RWOFS_HI) begin
            net_rdata_nxt = rwofs_r[15:8];
        end else if (net_addr == `LCR_ADDR_ALIAS_LO) begin
            net_rdata_nxt = alias_r[7:0];
        end else if (net_addr == `LCR_ADDR_ALIAS_HI) begin
            net_rdata_nxt = alias_r[15:8];
        end
    end

    always @* begin
        host_rdata_nxt = 8'h00;
        if (host_addr == `LCR_ADDR_RST_KEY) begin
            host_rdata_nxt = {6'h00, prog_r};
        end else if (host_addr == `LCR_ADDR_CTRL_B0) begin
            host_rdata_nxt = ctrl_r[7:0];
        end else if (host_addr == `LCR_ADDR_CTRL_B1) begin
            host_rdata_nxt = ctrl_r[15:8];
        end else if (host_addr == `LCR_ADDR_CTRL_B2) begin
            host_rdata_nxt = ctrl_r[23:16];
        end else if (host_addr == `LCR_ADDR_CTRL_B3) begin
            host_rdata_nxt = ctrl_r[31:24];
        end else if (host_addr == `LCR_ADDR_RWOFS_LO) begin
            host_rdata_nxt = rwofs_r[7:0];
        end else if (host_addr == `LCR_ADDR_RWOFS_HI) begin
            host_rdata_nxt = rwofs_r[15:8];
        end else if (host_addr == `LCR_ADDR_ALIAS_LO) begin
            host_rdata_nxt = alias_r[7:0];
        end else if (host_addr == `LCR_ADDR_ALIAS_HI) begin
            host_rdata_nxt = alias_r[15:8];
        end
    end

    // ==========================================================
    // Read data registers: answer one cycle after the strobe, hold until the next read
    always @(posedge clk) begin
        if (rst) begin
            net_rdata  <= 8'h00;
            host_rdata <= 8'h00;
        end else begin
            if (net_rd) begin
                net_rdata <= net_rdata_nxt;
            end
            if (host_rd) begin
                host_rdata <= host_rdata_nxt;
            end
        end
    end

    // ==========================================================
    // Per-port loop application, held while a frame is in flight
    genvar p;
    generate
        for (p = 0; p < NPORTS; p = p + 1) begin : g_loop
            always @(posedge clk) begin
                if (rst) begin
                    loop_applied[2*p+1:2*p] <= 2'h0;
                end else if (!port_busy[p]) begin
                    loop_applied[2*p+1:2*p] <= loop_ctrl[2*p+1:2*p];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Receive delay reduction in 10 ns units per port type.
    // The differential port gains 10 ns per code step up to code 5; the MII ports only
    // have one fixed step, so larger codes leave their delay alone.
    always @* begin
        case (ctrl_r[18:16])
            3'h0: begin
                diff_red_nxt = 4'h5;
                mii_red_nxt  = 1'b1;
            end
            3'h1: begin
                diff_red_nxt = 4'h4;
                mii_red_nxt  = 1'b1;
            end
            3'h2: begin
                diff_red_nxt = 4'h3;
                mii_red_nxt  = 1'b1;
            end
            3'h3: begin
                diff_red_nxt = 4'h2;
                mii_red_nxt  = 1'b1;
            end
            3'h4: begin
                diff_red_nxt = 4'h1;
                mii_red_nxt  = 1'b0;
            end
            default: begin
                diff_red_nxt = 4'h0;
                mii_red_nxt  = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Applied settings and datapath helpers, all registered
    always @(posedge clk) begin
        if (rst) begin
            alias_match_en      <= 1'b0;
            station_alias       <= 16'h0000;
            low_jitter          <= 1'b0;
            rx_fifo_size        <= `LCR_FIFO_DEFAULT;
            diff_delay_red      <= 4'h0;
            mii_delay_red       <= 1'b0;
            drop_non_fieldbus   <= 1'b1;
            cmd_wr_addr         <= 16'h0000;
            fwd_sender_bit1_out <= 1'b1;
        end else begin
            alias_match_en    <= ctrl_r[`LCR_BIT_ALIAS_EN];
            station_alias     <= alias_r;
            low_jitter        <= ctrl_r[`LCR_BIT_JITTER];
            rx_fifo_size      <= ctrl_r[18:16];
            drop_non_fieldbus <= ctrl_r[`LCR_BIT_FWD_RULE];
            diff_delay_red    <= diff_red_nxt;
            mii_delay_red     <= mii_red_nxt;
            cmd_wr_addr       <= cmd_sum[15:0];
            fwd_sender_bit1_out <= fwd_sender_bit1_in | 1'b1;
        end
    end

endmodule

// ===== verification/lcr_frame_src.sv
`timescale 1ns/10ps
// ==========================================
// Far-side frame source: one frame of LEN cycles per start pulse
module lcr_frame_src #(
    parameter LEN = 30
) (
    input  wire       clk,
    input  wire       rst,
    input  wire [2:0] go,
    output wire [2:0] port_busy
);
    reg [7:0] cnt_r;
    reg [2:0] sel_r;
    // A start while a frame runs is ignored, as a real link cannot overlap
    always @(posedge clk) begin
        if (rst)
            cnt_r <= 8'h00;
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
        else if (go != 3'h0)
            cnt_r <= LEN[7:0];
        if (cnt_r == 8'h00)
            sel_r <= go;
    end
    assign port_busy = (cnt_r != 8'h00) ? sel_r : 3'h0;
endmodule

// ===== verification/lcr_regs_sva.sv
`timescale 1ns/10ps
// ==========================================
// Port checker for the link control registers
module lcr_regs_sva (
    input wire        clk,
    input wire        rst,
    input wire        net_wr,
    input wire        net_rd,
    input wire [15:0] net_addr,
    input wire [7:0]  net_wdata,
    input wire [7:0]  net_rdata,
    input wire        host_wr,
    input wire        host_rd,
    input wire [15:0] host_addr,
    input wire [7:0]  host_wdata,
    input wire [7:0]  host_rdata,
    input wire [2:0]  port_busy,
    input wire [15:0] cmd_addr,
    input wire [15:0] cmd_wr_addr,
    input wire        host_if_reset,
    input wire        alias_match_en,
    input wire        low_jitter,
    input wire [2:0]  rx_fifo_size,
    input wire        drop_non_fieldbus,
    input wire [5:0]  loop_applied
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    reg  [1:0]  prog_r;
    reg  [15:0] ofs_r;
    wire        key_wr = host_wr && host_addr == 16'h0041;
    wire        fire   = key_wr && host_wdata == 8'h53 && prog_r == 2'h2;
    wire        nw_102 = net_wr && net_addr == 16'h0102;
    // ==========================================
    // Mirrors; any host write off the key breaks the chain
    always @(posedge clk) begin
        if (rst)
            prog_r <= 2'h0;
        else if (host_wr)
            prog_r <= !key_wr ? 2'h0 : (host_wdata == 8'h52) ? 2'h1 :
                      (host_wdata == 8'h45 && prog_r == 2'h1) ? 2'h2 : 2'h0;
    end
    always @(posedge clk) begin
        if (rst)
            ofs_r <= 16'h0000;
        else if (net_wr && net_addr == 16'h0108)
            ofs_r[7:0] <= net_wdata;
        else if (net_wr && net_addr == 16'h0109)
            ofs_r[15:8] <= net_wdata;
    end
    // ==========================================
    // Assertions; settings land two edges after the write
    key_reset_a: assert property (!$past(rst) |-> host_if_reset == $past(fire)) else $error("bad reset");
    key_prog_a: assert property (host_rd && host_addr == 16'h0041 |=> host_rdata == {6'h00, $past(prog_r)})
        else $error("bad progress");
    net_view_a: assert property (net_rd && net_addr == 16'h0041 |=> net_rdata == {6'h00, $past(prog_r)})
        else $error("bad net view");
    alias_en_a: assert property (net_wr && net_addr == 16'h0103 |=> ##1 alias_match_en == $past(net_wdata[0], 2))
        else $error("bad alias");
    jitter_sel_a: assert property (nw_102 |=> ##1 low_jitter == $past(net_wdata[3], 2)) else $error("bad jitter");
    fifo_size_a: assert property (nw_102 |=> ##1 rx_fifo_size == $past(net_wdata[2:0], 2)) else $error("bad fifo");
    loop_hold_a: assert property (port_busy[0] |=> $stable(loop_applied[1:0])) else $error("bad hold");
    fwd_rule_a: assert property (net_wr && net_addr == 16'h0100 |=> ##1 drop_non_fieldbus == $past(net_wdata[0], 2))
        else $error("bad rule");
    rw_offset_a: assert property (!$past(rst) |-> cmd_wr_addr == $past(cmd_addr) + $past(ofs_r))
        else $error("bad offset");
    cover property (fire);
    cover property (nw_102);
    cover property (port_busy[0] && net_wr && net_addr == 16'h0101);
endmodule

// ===== verification/test_link_control_and_host_reset_regs.sv
`timescale 1ns/10ps
module test_link_control_and_host_reset_regs;
    localparam TEMP = 20;
    reg         clk = 1'b0, rst = 1'b1, net_wr = 1'b0, net_rd = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
    reg         fwd_sender_bit1_in = 1'b0;
    reg  [15:0] net_addr = 16'h0000, host_addr = 16'h0000, cmd_addr = 16'h0000;
    reg  [7:0]  net_wdata = 8'h00, host_wdata = 8'h00, rd_q;
    reg  [2:0]  go = 3'h0;
    wire [7:0]  net_rdata, host_rdata;
    wire [15:0] cmd_wr_addr, station_alias;
    wire [5:0]  loop_applied;
    wire [3:0]  diff_delay_red;
    wire [2:0]  port_busy, rx_fifo_size;
    wire        fwd_sender_bit1_out, host_if_reset, alias_match_en, low_jitter, mii_delay_red, drop_non_fieldbus;
    integer     miscompares = 0, checked = 0, cycles = 0, i;
    lcr_regs #(.TEMP_CYCLES(TEMP)) dut (
        .clk                 (clk),
        .rst                 (rst),
        .net_wr              (net_wr),
        .net_rd              (net_rd),
        .net_addr            (net_addr),
        .net_wdata           (net_wdata),
        .net_rdata           (net_rdata),
        .host_wr             (host_wr),
        .host_rd             (host_rd),
        .host_addr           (host_addr),
        .host_wdata          (host_wdata),
        .host_rdata          (host_rdata),
        .port_busy           (port_busy),
        .cmd_addr            (cmd_addr),
        .cmd_wr_addr         (cmd_wr_addr),
        .fwd_sender_bit1_in  (fwd_sender_bit1_in),
        .fwd_sender_bit1_out (fwd_sender_bit1_out),
        .host_if_reset       (host_if_reset),
        .alias_match_en      (alias_match_en),
        .station_alias       (station_alias),
        .low_jitter          (low_jitter),
        .rx_fifo_size        (rx_fifo_size),
        .diff_delay_red      (diff_delay_red),
        .mii_delay_red       (mii_delay_red),
        .loop_applied        (loop_applied),
        .drop_non_fieldbus   (drop_non_fieldbus)
    );
    lcr_frame_src #(.LEN(30)) src (.clk(clk), .rst(rst), .go(go), .port_busy(port_busy));
    // ==========================================
    // Clock and a hang limit well above the expected run
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            results;
        end
    end
    // ==========================================
    // One byte access; both sides share address and data, strobes pick the side
    task acc(input h, input w, input [15:0] a, input [7:0] d);
        @(posedge clk);
        {net_addr, host_addr, net_wdata, host_wdata} <= {a, a, d, d};
        {net_wr, net_rd, host_wr, host_rd} <= {!h && w, !h && !w, h && w, h && !w};
        @(posedge clk);
        {net_wr, net_rd, host_wr, host_rd} <= 4'h0;
        #1 rd_q = h ? host_rdata : net_rdata;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task rc(input h, input [15:0] a, input [7:0] e);
        acc(h, 1'b0, a, 8'h00);
        chk(rd_q, e);
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task results;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rc(1'b0, 16'h0100, 8'h01);
        rc(1'b0, 16'h0102, 8'h07);
        rc(1'b0, 16'h0200, 8'h00);
        chk(fwd_sender_bit1_out, 1);
        $display("Test done: reset values");
        acc(1'b1, 1'b1, 16'h0041, 8'h52);
        rc(1'b1, 16'h0041, 8'h01);
        acc(1'b1, 1'b1, 16'h0041, 8'h45);
        acc(1'b0, 1'b1, 16'h0041, 8'h00);
        rc(1'b0, 16'h0041, 8'h02);
        acc(1'b1, 1'b1, 16'h0041, 8'h53);
        chk(host_if_reset, 1);
        rc(1'b1, 16'h0041, 8'h00);
        chk(host_if_reset, 0);
        // Host write elsewhere must break the chain, and is itself refused
        acc(1'b1, 1'b1, 16'h0041, 8'h52);
        acc(1'b1, 1'b1, 16'h0041, 8'h45);
        acc(1'b1, 1'b1, 16'h0100, 8'h00);
        acc(1'b1, 1'b1, 16'h0041, 8'h53);
        chk(host_if_reset, 0);
        rc(1'b0, 16'h0100, 8'h01);
        $display("Test done: reset key");
        acc(1'b1, 1'b1, 16'h0012, 8'hCD);
        acc(1'b1, 1'b1, 16'h0013, 8'hAB);
        acc(1'b0, 1'b1, 16'h0012, 8'h00);
        acc(1'b0, 1'b1, 16'h0103, 8'h01);
        tick(2);
        chk({alias_match_en, station_alias}, {1'b1, 16'hABCD});
        rc(1'b0, 16'h0013, 8'hAB);
        $display("Test done: alias");
        for (i = 0; i < 8; i = i + 1) begin
            acc(1'b0, 1'b1, 16'h0102, 8'h08 | i[7:0]);
            tick(2);
            chk({low_jitter, rx_fifo_size, diff_delay_red, mii_delay_red},
                {1'b1, i[2:0], (i < 5) ? 4'h5 - i[3:0] : 4'h0, i < 4});
        end
        acc(1'b0, 1'b1, 16'h0102, 8'h07);
        rc(1'b0, 16'h0102, 8'h07);
        $display("Test done: fifo and delay");
        acc(1'b0, 1'b1, 16'h0108, 8'h34);
        acc(1'b0, 1'b1, 16'h0109, 8'h12);
        @(posedge clk);
        cmd_addr <= 16'hF000;
        tick(2);
        chk(cmd_wr_addr, 16'h0234);
        rc(1'b1, 16'h0109, 8'h12);
        acc(1'b0, 1'b1, 16'h0100, 8'h00);
        tick(2);
        chk(drop_non_fieldbus, 0);
        $display("Test done: offset and rule");
        @(posedge clk);
        go <= 3'h1;
        @(posedge clk);
        go <= 3'h0;
        acc(1'b0, 1'b1, 16'h0101, 8'h1B);
        tick(2);
        chk(loop_applied, 6'h18);
        tick(30);
        chk(loop_applied, 6'h1B);
        acc(1'b0, 1'b1, 16'h0100, 8'h03);
        acc(1'b0, 1'b1, 16'h0101, 8'h3F);
        tick(2);
        chk(loop_applied, 6'h3F);
        tick(TEMP + 2);
        chk(loop_applied, 6'h1B);
        rc(1'b0, 16'h0101, 8'h1B);
        $display("Test done: loop control");
        results;
    end
endmodule
bind lcr_regs lcr_regs_sva sva (
    .clk               (clk),
    .rst               (rst),
    .net_wr            (net_wr),
    .net_rd            (net_rd),
    .net_addr          (net_addr),
    .net_wdata         (net_wdata),
    .net_rdata         (net_rdata),
    .host_wr           (host_wr),
    .host_rd           (host_rd),
    .host_addr         (host_addr),
    .host_wdata        (host_wdata),
    .host_rdata        (host_rdata),
    .port_busy         (port_busy),
    .cmd_addr          (cmd_addr),
    .cmd_wr_addr       (cmd_wr_addr),
    .host_if_reset     (host_if_reset),
    .alias_match_en    (alias_match_en),
    .low_jitter        (low_jitter),
    .rx_fifo_size      (rx_fifo_size),
    .drop_non_fieldbus (drop_non_fieldbus),
    .loop_applied      (loop_applied)
);
